// ---- core/frdc_read_cmd.sv ----
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module frdc_read_cmd import frdc_pkg::*; #(
  parameter int UNIT_CYC = STEP_UNIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BYTE_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [BYTE_W-1:0] rdata,
  // drive side
  input wire logic sector_found,
  input wire logic found_deleted,
  input wire logic disk_byte_valid,
  input wire logic [7:0] disk_byte,
  output logic sector_req,
  output frdc_chrn_t req_id,
  output logic [1:0] drive_sel,
  output logic double_density_select,
  output logic step_pulse,
  output logic step_dir,
  output logic write_enable,
  output logic pre_erase_lead,
  // interrupt
  output logic irq
);
  frdc_state_t state_q, state_d;
  logic [3:0] idx_q, idx_d;
  logic [7:0] cmd_q [9];
  logic [7:0] cmd_d [9];
  frdc_chrn_t cur_q, cur_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] sec_cnt_q, sec_cnt_d;
  logic [7:0] data_q, data_d;
  logic rdy_q, rdy_d, ovr_q, ovr_d, mark_q, mark_d;
  logic [7:0] stat0_q, stat0_d, stat1_q, stat1_d, stat2_q, stat2_d, stat3_q, stat3_d;
  logic [7:0] rdata_d;
  logic req_d;
  frdc_cfg_t cfg_q, cfg_d;
  logic [7:0] cyl_pos_q, cyl_pos_d;
  logic dir_d, seek_start;
  logic [7:0] seek_steps;
  logic seek_busy, seek_done;
  logic [IRQ_N-1:0] irq_ev, irq_st, irq_en;
  logic wr_data, rd_data, is_read, is_del, multi, skip_set, want_del, last_sec, count_end;
  logic [15:0] sec_len;

  assign wr_data = we && (addr == A_DATA);
  assign rd_data = re && (addr == A_DATA);
  assign is_read = (cmd_q[0][4:0] == OPC_READ);
  assign is_del = (cmd_q[0][4:0] == OPC_READ_DEL);
  assign multi = cmd_q[0][BIT_MULTI];
  assign skip_set = cmd_q[0][BIT_SKIP];
  assign want_del = is_del;
  assign sec_len = (cmd_q[5][2:0] == 3'h0) ? {8'h00, cmd_q[8]} : SECTOR_BASE_LEN << cmd_q[5][2:0];
  assign last_sec = (cur_q.sector == cmd_q[6]);
  assign count_end = cfg_q.count_enable_flag && (sec_cnt_q + 8'h01 >= cfg_q.sectors_per_track);
  assign seek_start = we && (addr == A_SEEK) && !seek_busy;
  assign seek_steps = wdata[7] ? 8'h00 - wdata : wdata;
  assign dir_d = seek_start ? !wdata[7] : step_dir;
  assign cyl_pos_d = (seek_start && !seek_busy) ? cyl_pos_q + wdata : cyl_pos_q;

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    cmd_d = cmd_q;
    cur_d = cur_q;
    cnt_d = cnt_q;
    sec_cnt_d = sec_cnt_q;
    data_d = data_q;
    rdy_d = rdy_q && !(rd_data && state_q != S_CMD && state_q != S_RESULT);
    ovr_d = ovr_q;
    mark_d = mark_q;
    stat0_d = stat0_q;
    stat1_d = stat1_q;
    stat2_d = stat2_q;
    stat3_d = stat3_q;
    req_d = 1'b0;
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    if (we && addr == A_CFG) begin
      cfg_d.step_rate_interval = wdata[7:4];
      cfg_d.write_gate_timing = wdata[1];
      cfg_d.count_enable_flag = wdata[0];
    end
    if (we && addr == A_SPT) begin
      cfg_d.sectors_per_track = wdata;
    end
    unique case (state_q)
      S_CMD: begin
        if (wr_data) begin
          cmd_d[idx_q] = wdata;
          idx_d = idx_q + 4'h1;
          if (idx_q == IDX_CMD_LAST) begin
            idx_d = 4'h0;
            cur_d = '{cmd_q[2], cmd_q[3], cmd_q[4], cmd_q[5]};
            sec_cnt_d = 8'h00;
            ovr_d = 1'b0;
            mark_d = 1'b0;
            state_d = (is_read || is_del) ? S_REQ : S_RESULT;
            stat0_d = (is_read || is_del) ? 8'h00 : STAT0_INVALID;
            stat1_d = 8'h00;
            stat2_d = 8'h00;
          end
        end
      end
      S_REQ: begin
        req_d = 1'b1;
        state_d = S_WAIT;
      end
      S_WAIT: begin
        if (sector_found) begin
          if (skip_set && (found_deleted != want_del)) begin
            state_d = S_NEXT;
          end else begin
            mark_d = mark_q || (found_deleted != want_del);
            cnt_d = sec_len;
            state_d = (sec_len == 16'h0000) ? S_NEXT : S_DATA;
          end
        end
      end
      S_DATA: begin
        if (disk_byte_valid) begin
          data_d = disk_byte;
          rdy_d = 1'b1;
          ovr_d = ovr_q || (rdy_q && !rd_data);
          cnt_d = cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_d = S_NEXT;
          end
        end
      end
      S_NEXT: begin
        // hold until the host takes the last byte, else the result hides it
        if (!rdy_q) begin
          sec_cnt_d = sec_cnt_q + 8'h01;
          state_d = S_REQ;
          if (count_end || (last_sec && !(multi && cur_q.head[0] == 1'b0))) begin
            state_d = S_RESULT;
            stat0_d = {5'h00, cur_q.head[0], cmd_q[1][1:0]};
            stat1_d = ovr_q ? STAT1_OVERRUN : 8'h00;
            stat2_d = mark_q ? STAT2_CTRL_MARK : 8'h00;
          end else if (last_sec) begin
            cur_d.head = 8'h01;
            cur_d.sector = FIRST_SECTOR;
          end else begin
            cur_d.sector = cur_q.sector + 8'h01;
          end
        end
      end
      S_RESULT: begin
        stat3_d = STAT3_READY | {5'h00, cur_q.head[0], cmd_q[1][1:0]};
        if (rd_data) begin
          idx_d = idx_q + 4'h1;
          if (idx_q == IDX_RES_LAST) begin
            idx_d = 4'h0;
            state_d = S_CMD;
          end
        end
      end
    endcase
    if (re) begin
      unique case (addr)
        A_DATA: begin
          if (state_q == S_RESULT) begin
            unique case (idx_q)
              4'h0: rdata_d = stat0_q;
              4'h1: rdata_d = stat1_q;
              4'h2: rdata_d = stat2_q;
              4'h3: rdata_d = cur_q.cyl;
              4'h4: rdata_d = cur_q.head;
              4'h5: rdata_d = cur_q.sector;
              default: rdata_d = cur_q.size;
            endcase
          end else if (state_q == S_DATA || state_q == S_NEXT || state_q == S_REQ ||
                       state_q == S_WAIT) begin
            rdata_d = data_q;
          end
        end
        A_PHASE: rdata_d = {state_q == S_CMD, state_q == S_RESULT,
                            state_q != S_CMD && state_q != S_RESULT, rdy_q, seek_busy,
                            idx_q[2:0]};
        A_CFG: rdata_d = {cfg_q.step_rate_interval, 2'b00, cfg_q.write_gate_timing,
                          cfg_q.count_enable_flag};
        A_SPT: rdata_d = cfg_q.sectors_per_track;
        A_CYL_POS: rdata_d = cyl_pos_q;
        A_STAT3: rdata_d = (state_q == S_RESULT) ? stat3_q : 8'h00;
        A_IRQ_ST: rdata_d = {5'h00, irq_st};
        A_IRQ_EN: rdata_d = {5'h00, irq_en};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= S_CMD;
      idx_q <= 4'h0;
      cmd_q <= '{default: 8'h00};
      cur_q <= '0;
      cnt_q <= 16'h0000;
      sec_cnt_q <= 8'h00;
      data_q <= 8'h00;
      rdy_q <= 1'b0;
      ovr_q <= 1'b0;
      mark_q <= 1'b0;
      stat0_q <= 8'h00;
      stat1_q <= 8'h00;
      stat2_q <= 8'h00;
      stat3_q <= 8'h00;
      rdata <= 8'h00;
      sector_req <= 1'b0;
      cfg_q <= CFG_RST;
      cyl_pos_q <= 8'h00;
      step_dir <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      cmd_q <= cmd_d;
      cur_q <= cur_d;
      cnt_q <= cnt_d;
      sec_cnt_q <= sec_cnt_d;
      data_q <= data_d;
      rdy_q <= rdy_d;
      ovr_q <= ovr_d;
      mark_q <= mark_d;
      stat0_q <= stat0_d;
      stat1_q <= stat1_d;
      stat2_q <= stat2_d;
      stat3_q <= stat3_d;
      rdata <= rdata_d;
      sector_req <= req_d;
      cfg_q <= cfg_d;
      cyl_pos_q <= cyl_pos_d;
      step_dir <= dir_d;
    end
  end

  // drive-facing copies of command fields and of the write-gate timing config bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_id <= '0;
      drive_sel <= 2'b00;
      double_density_select <= 1'b0;
      write_enable <= 1'b0;
      pre_erase_lead <= 1'b0;
    end else begin
      req_id <= cur_d;
      drive_sel <= cmd_q[1][1:0];
      double_density_select <= cmd_q[0][BIT_DENSITY];
      // reads never write; gate stays low
      write_enable <= 1'b0;
      pre_erase_lead <= cfg_q.write_gate_timing;
    end
  end

  frdc_step_timer #(.UNIT_CYC(UNIT_CYC)) u_step (
    .clk(clk),
    .nrst(nrst),
    .start(seek_start),
    .steps(seek_steps),
    .rate(cfg_q.step_rate_interval),
    .step_pulse(step_pulse),
    .busy(seek_busy),
    .done(seek_done)
  );

  assign irq_ev = {disk_byte_valid && state_q == S_DATA, seek_done,
                   state_q != S_RESULT && state_d == S_RESULT};

  frdc_irq #(.N(IRQ_N)) u_irq (
    .clk(clk),
    .nrst(nrst),
    .events(irq_ev),
    .clr_we(we && addr == A_IRQ_CLR),
    .en_we(we && addr == A_IRQ_EN),
    .wdata(wdata[IRQ_N-1:0]),
    .status(irq_st),
    .enable(irq_en),
    .irq(irq)
  );

  sequence s_last_cmd_byte;
    state_q == S_CMD && idx_q == IDX_CMD_LAST && wr_data;
  endsequence

  AST_READ_DECODE: assert property (@(posedge clk) disable iff (!nrst)
    s_last_cmd_byte ##0 (cmd_q[0][4:0] == OPC_READ) |=> state_q == S_REQ ##1 sector_req)
    else $error("read opcode did not start execution");
  AST_NO_OPCODE_BUSY: assert property (@(posedge clk) disable iff (!nrst)
    wr_data && state_q == S_RESULT |=> cmd_q[0] == $past(cmd_q[0]))
    else $error("command byte taken during result phase");
  AST_EXEC_REQ: assert property (@(posedge clk) disable iff (!nrst)
    sector_req |-> state_q == S_WAIT) else $error("sector request outside execution");
  AST_RESULT_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    rd_data && state_q == S_RESULT && idx_q == 4'h0 |=> rdata == $past(stat0_q))
    else $error("first result byte is not status 0");
  AST_SKIP_DELETED: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_WAIT && sector_found && found_deleted && skip_set && is_read
    |=> state_q == S_NEXT)
    else $error("deleted sector not skipped");
  AST_NOSKIP_READ: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_WAIT && sector_found && !skip_set && sec_len != 16'h0000 |=> state_q == S_DATA)
    else $error("sector not read with skip clear");
  AST_SECTOR_LEN: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_WAIT && sector_found && !skip_set |=> cnt_q == $past(sec_len))
    else $error("byte count not loaded from size code");
  AST_MULTI_HEAD1: assert property (@(posedge clk) disable iff (!nrst)
    state_q == S_NEXT && !rdy_q && multi && cur_q.head == 8'h00 && last_sec && !count_end
    |=> cur_q.head == 8'h01 && cur_q.sector == FIRST_SECTOR)
    else $error("multi-track did not move to head 1");
  AST_STAT3_HIDDEN: assert property (@(posedge clk) disable iff (!nrst)
    re && addr == A_STAT3 && state_q != S_RESULT |=> rdata == 8'h00)
    else $error("status readable outside result phase");
endmodule
`default_nettype wire

// ---- core/frdc_pkg.sv ----
package frdc_pkg;
  localparam int ADDR_W = 4;
  localparam int BYTE_W = 8;

  // register addresses
  localparam logic [3:0] A_DATA = 4'h0;
  localparam logic [3:0] A_PHASE = 4'h1;
  localparam logic [3:0] A_CFG = 4'h2;
  localparam logic [3:0] A_SPT = 4'h3;
  localparam logic [3:0] A_SEEK = 4'h4;
  localparam logic [3:0] A_STAT3 = 4'h5;
  localparam logic [3:0] A_CYL_POS = 4'h6;
  localparam logic [3:0] A_IRQ_ST = 4'h7;
  localparam logic [3:0] A_IRQ_CLR = 4'h8;
  localparam logic [3:0] A_IRQ_EN = 4'h9;

  // command and result framing
  localparam logic [3:0] IDX_CMD_LAST = 4'h8;
  localparam logic [3:0] IDX_RES_LAST = 4'h6;
  localparam logic [4:0] OPC_READ = 5'h06;
  localparam logic [4:0] OPC_READ_DEL = 5'h0c;
  localparam int BIT_MULTI = 7;
  localparam int BIT_DENSITY = 6;
  localparam int BIT_SKIP = 5;
  localparam int BIT_HEAD = 2;

  // step timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_UNIT_NS = 500_000;
  localparam int STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] STEP_SPAN = 5'h10;

  localparam logic [15:0] SECTOR_BASE_LEN = 16'h0080;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;

  // status bits
  localparam logic [7:0] STAT0_INVALID = 8'h80;
  localparam logic [7:0] STAT1_OVERRUN = 8'h10;
  localparam logic [7:0] STAT2_CTRL_MARK = 8'h40;
  localparam logic [7:0] STAT3_READY = 8'h20;

  // interrupt sources
  localparam int IRQ_N = 3;
  localparam int IRQ_RESULT = 0;
  localparam int IRQ_SEEK = 1;
  localparam int IRQ_BYTE = 2;

  typedef struct packed {
    logic [3:0] step_rate_interval;
    logic write_gate_timing;
    logic count_enable_flag;
    logic [7:0] sectors_per_track;
  } frdc_cfg_t;

  localparam frdc_cfg_t CFG_RST = '{4'h0, 1'b0, 1'b0, 8'h09};

  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } frdc_chrn_t;

  typedef enum logic [2:0] {S_CMD, S_REQ, S_WAIT, S_DATA, S_NEXT, S_RESULT} frdc_state_t;
endpackage

// ---- core/frdc_step_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module frdc_step_timer import frdc_pkg::*; #(
  parameter int UNIT_CYC = STEP_UNIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic [7:0] steps,
  input wire logic [3:0] rate,
  // outputs
  output logic step_pulse,
  output logic busy,
  output logic done
);
  localparam int PW = $clog2(UNIT_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYC - 1);

  logic [PW-1:0] pre_q, pre_d;
  logic [4:0] ivl_q, ivl_d;
  logic [7:0] left_q, left_d;
  logic busy_d, step_d, done_d;
  logic tick;

  assign tick = busy && (pre_q == PRE_LAST);

  always_comb begin
    pre_d = '0;
    ivl_d = ivl_q;
    left_d = left_q;
    busy_d = busy;
    step_d = 1'b0;
    done_d = 1'b0;
    if (start && !busy) begin
      ivl_d = STEP_SPAN - {1'b0, rate};
      left_d = steps;
      busy_d = (steps != 8'h00);
      done_d = (steps == 8'h00);
    end else if (busy) begin
      pre_d = tick ? '0 : pre_q + 1'b1;
      if (tick) begin
        ivl_d = ivl_q - 5'h01;
        if (ivl_q == 5'h01) begin
          step_d = 1'b1;
          ivl_d = STEP_SPAN - {1'b0, rate};
          left_d = left_q - 8'h01;
          if (left_q == 8'h01) begin
            busy_d = 1'b0;
            done_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_q <= '0;
      ivl_q <= 5'h00;
      left_q <= 8'h00;
      busy <= 1'b0;
      step_pulse <= 1'b0;
      done <= 1'b0;
    end else begin
      pre_q <= pre_d;
      ivl_q <= ivl_d;
      left_q <= left_d;
      busy <= busy_d;
      step_pulse <= step_d;
      done <= done_d;
    end
  end

  AST_STEP_ONE_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
    step_pulse |=> !step_pulse) else $error("step pulse longer than one cycle");
endmodule
`default_nettype wire

// ---- core/frdc_irq.sv ----
`timescale 1ns/1ps
`default_nettype none
module frdc_irq import frdc_pkg::*; #(
  parameter int N = IRQ_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // events and software access
  input wire logic [N-1:0] events,
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [N-1:0] wdata,
  // state
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  logic [N-1:0] status_d, enable_d;

  always_comb begin
    // a new event wins over a clear in the same cycle
    status_d = (status & ~(clr_we ? wdata : '0)) | events;
    enable_d = en_we ? wdata : enable;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      status <= '0;
      enable <= '0;
      irq <= 1'b0;
    end else begin
      status <= status_d;
      enable <= enable_d;
      irq <= |(status_d & enable_d);
    end
  end
endmodule
`default_nettype wire

// ---- core/frdc_pkg_unused_guard.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- testbench/frdc_drive_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module frdc_drive_model import frdc_pkg::*; (
  // clock
  input wire logic clk,
  // requests
  input wire logic sector_req,
  input wire frdc_chrn_t req_id,
  // behaviour knobs
  input wire logic [15:0] del_map,
  input wire logic [7:0] lat,
  input wire logic [9:0] nbytes,
  // answers
  output logic sector_found,
  output logic found_deleted,
  output logic disk_byte_valid,
  output logic [7:0] disk_byte
);
  int n_req = 0;
  int seen = 0;
  frdc_chrn_t last_id;
  frdc_chrn_t cur;
  always @(posedge clk) begin
    if (sector_req) begin
      n_req <= n_req + 1;
      last_id <= req_id;
    end
  end
  initial begin
    sector_found = 1'b0;
    found_deleted = 1'b0;
    disk_byte_valid = 1'b0;
    disk_byte = 8'h00;
    forever begin
      @(posedge clk);
      if (n_req != seen) begin
        seen = n_req;
        cur = last_id;
        repeat (lat) @(posedge clk);
        sector_found <= 1'b1;
        found_deleted <= del_map[cur.sector[3:0]];
        // a new request aborts the stream, as a real head moves on
        for (int k = 0; k < 6 * nbytes && n_req == seen; k++) begin
          @(posedge clk);
          sector_found <= 1'b0;
          found_deleted <= !del_map[cur.sector[3:0]];
          disk_byte_valid <= (k % 6 == 5);
          disk_byte <= (k % 6 == 5) ? {cur.sector[3:0], 4'(k / 6)} : ~disk_byte;
        end
        @(posedge clk);
        disk_byte_valid <= 1'b0;
        sector_found <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/frdc_read_cmd_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module frdc_read_cmd_tb import frdc_pkg::*;;
  logic clk, nrst, we, re, sector_found, found_deleted, disk_byte_valid, sector_req;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, disk_byte, lat, v;
  logic [15:0] del_map;
  logic [9:0] nbytes;
  logic [1:0] drive_sel;
  logic double_density_select, step_pulse, step_dir, write_enable, pre_erase_lead, irq;
  frdc_chrn_t req_id;
  frdc_chrn_t req_log[$];
  logic [7:0] got_q[$];
  logic [7:0] res[7];
  int failures = 0;
  int n_compared = 0;
  int cyc = 0, n_steps = 0, last_step = 0, step_gap = 0, s0;

  frdc_read_cmd #(.UNIT_CYC(4)) DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .sector_found(sector_found),
    .found_deleted(found_deleted), .disk_byte_valid(disk_byte_valid), .disk_byte(disk_byte),
    .sector_req(sector_req), .req_id(req_id), .drive_sel(drive_sel),
    .double_density_select(double_density_select), .step_pulse(step_pulse),
    .step_dir(step_dir), .write_enable(write_enable), .pre_erase_lead(pre_erase_lead),
    .irq(irq));
  frdc_drive_model drive (.clk(clk), .sector_req(sector_req), .req_id(req_id),
    .del_map(del_map), .lat(lat), .nbytes(nbytes), .sector_found(sector_found),
    .found_deleted(found_deleted), .disk_byte_valid(disk_byte_valid), .disk_byte(disk_byte));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sector_req) req_log.push_back(req_id);
    if (step_pulse) begin
      n_steps <= n_steps + 1;
      step_gap <= cyc - last_step;
      last_step <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic complete_run;
    $display("failures %0d n_compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // command bytes, drain data, read results
  task automatic run_cmd(input logic [7:0] op, r, end_of_track_sector, n, input logic [15:0] dm,
                         input logic [9:0] nb);
    logic [7:0] b[9];
    logic [7:0] ph;
    logic [7:0] d;
    b = '{op, 8'h02, 8'h03, 8'h00, r, n, end_of_track_sector, 8'h1b, 8'h04};
    del_map <= dm;
    nbytes <= nb;
    got_q.delete();
    req_log.delete();
    foreach (b[i]) wr(A_DATA, b[i]);
    ph = 8'h00;
    for (int t = 0; t < 3000 && !ph[6]; t++) begin
      rd(A_PHASE, ph);
      if (ph[4] && !ph[6]) begin
        rd(A_DATA, d);
        got_q.push_back(d);
      end
    end
    wr(A_DATA, 8'h06);
    rd(A_PHASE, ph);
    chk(ph, 8'h40);
    chk(irq, 1'b1);
    rd(A_IRQ_ST, d);
    chk(d, {5'h00, got_q.size() != 0, 2'b01});
    rd(A_STAT3, d);
    chk(d & 8'hfb, STAT3_READY | 8'h02);
    foreach (res[i]) rd(A_DATA, res[i]);
    rd(A_PHASE, ph);
    chk(ph, 8'h80);
    wr(A_IRQ_CLR, 8'h07);
    rd(A_IRQ_ST, d);
    chk(d, 8'h00);
    chk(irq, 1'b0);
  endtask
  task automatic chk_bytes(input logic [3:0] s, input int cnt);
    chk(got_q.size(), cnt);
    foreach (got_q[i]) chk(got_q[i], {s, 4'(i)});
  endtask

  initial begin
    nrst = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
    del_map = 16'h0000;
    lat = 8'h01;
    nbytes = 10'h004;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(A_PHASE, v);
    chk(v, 8'h80);
    rd(A_CFG, v);
    chk(v, 8'h00);
    rd(A_SPT, v);
    chk(v, 8'h09);
    rd(A_STAT3, v);
    chk(v, 8'h00);
    rd(4'hf, v);
    chk(v, 8'h00);
    chk(write_enable, 1'b0);
    wr(A_CFG, 8'hf3);
    rd(A_CFG, v);
    chk(v, 8'hf3);
    chk(pre_erase_lead, 1'b1);
    wr(A_CFG, 8'h00);
    wr(A_IRQ_EN, 8'h01);
    run_cmd(8'h07, 8'h01, 8'h01, 8'h00, 16'h0000, 10'h000);
    chk(res[0], 8'h80);
    run_cmd(8'h46, 8'h01, 8'h01, 8'h00, 16'h0000, 10'h004);
    chk(double_density_select, 1'b1);
    chk(drive_sel, 2'h2);
    chk(req_log[0], 32'h03000100);
    chk_bytes(4'h1, 4);
    chk({res[0], res[1], res[2]}, 24'h020000);
    chk({res[3], res[4], res[5], res[6]}, 32'h03000100);
    // slow drive for the skip cases
    lat <= 8'h14;
    run_cmd(8'h26, 8'h01, 8'h02, 8'h00, 16'h0002, 10'h004);
    chk(double_density_select, 1'b0);
    chk_bytes(4'h2, 4);
    chk({res[2], res[5]}, 16'h0002);
    run_cmd(8'h06, 8'h01, 8'h01, 8'h00, 16'h0002, 10'h004);
    chk_bytes(4'h1, 4);
    chk(res[2], 8'h40);
    run_cmd(8'h2c, 8'h01, 8'h02, 8'h00, 16'h0004, 10'h004);
    chk_bytes(4'h2, 4);
    chk(res[5], 8'h02);
    lat <= 8'h01;
    run_cmd(8'h86, 8'h01, 8'h01, 8'h00, 16'h0000, 10'h004);
    chk(req_log[1], 32'h03010100);
    chk(got_q.size(), 8);
    chk(res[4], 8'h01);
    run_cmd(8'h06, 8'h01, 8'h01, 8'h01, 16'h0000, 10'h100);
    chk_bytes(4'h1, 256);
    wr(A_CFG, 8'h01);
    wr(A_SPT, 8'h01);
    run_cmd(8'h06, 8'h01, 8'h02, 8'h00, 16'h0000, 10'h004);
    chk(req_log.size(), 1);
    wr(A_CFG, 8'hf0);
    // step spacing, direction and new cylinder
    for (int i = 0; i < 2; i++) begin
      s0 = n_steps;
      wr(A_SEEK, i ? 8'hfe : 8'h03);
      v = 8'h08;
      for (int t = 0; t < 300 && v[3]; t++) rd(A_PHASE, v);
      chk(n_steps - s0, i ? 2 : 3);
      chk(step_gap, i ? 64 : 4);
      chk(step_dir, !i);
      rd(A_CYL_POS, v);
      chk(v, i ? 8'h01 : 8'h03);
      wr(A_CFG, 8'h00);
    end
    // seek-done bit is set but masked until enabled
    rd(A_IRQ_ST, v);
    chk(v, 8'h02);
    chk(irq, 1'b0);
    wr(A_IRQ_EN, 8'h03);
    rd(A_IRQ_EN, v);
    chk(v, 8'h03);
    chk(irq, 1'b1);
    wr(A_IRQ_CLR, 8'h02);
    rd(A_IRQ_ST, v);
    chk(v, 8'h00);
    chk(irq, 1'b0);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
